// ==== rtl/tmb_master.v ====
// Two-wire bus master with arbitration, collision detection and baud counter behind APB.
//
// Summary of operation
// - Slave role keeps waking the processor during sleep; the module has no slave role.
// - Reset disables port and ends transfer.
// - Start/stop seen cleared on reset or disable.
// - Stop on busy bus raises event interrupt.
// - Released one read as zero is collision.
// - Byte collision halts, clears full, releases lines.
// - Sequence collision aborts and clears enable bit.
// - After collision, stop sets serial event flag.
// - New buffer write restarts from first bit.
// - Low line at start begin is collision.
// - Start counts with data high; clock low collides.
// - Data low during first count: assert early.
// - Second start count ignores clock; then clock low.
// - Repeated start: clock high, data low collides.
// - Clock falling before data driven is collision.
// - Both high at timeout: data low, clock low.
// - Stop: data low after timeout is collision.
// - Stop: clock low before data release collides.
// - Counter reloads from software value, stops when done.
// - Two reloads per bus clock period.
// - Buffer write during stop sets write collision.
`timescale 1ns/100ps
`include "tmb_regs.vh"
module tmb_master (
	input wire i_clk,
	input wire i_reset_n,
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [11:0] i_paddr,
	input wire [31:0] i_pwdata,
	output reg [31:0] o_prdata,
	output reg o_pready,
	output reg o_pslverr,
	input wire i_scl,
	output reg o_scl,
	output reg o_scl_oe_n,
	input wire i_sda,
	output reg o_sda,
	output reg o_sda_oe_n,
	output reg o_irq
);
	// ----------------------------------------------------------------
	// State codes, one-hot.
	// ----------------------------------------------------------------
	localparam [9:0] ST_IDLE = 10'h001;
	localparam [9:0] ST_S1 = 10'h002; // Start: data high, first count.
	localparam [9:0] ST_S2 = 10'h004; // Start: data low, second count.
	localparam [9:0] ST_R1 = 10'h008; // Restart: data released, count.
	localparam [9:0] ST_R2 = 10'h010; // Restart: clock released, wait high then count.
	localparam [9:0] ST_R3 = 10'h020; // Restart: data low, final count.
	localparam [9:0] ST_P1 = 10'h040; // Stop: data low, clock released.
	localparam [9:0] ST_P2 = 10'h080; // Stop: data released, count.
	localparam [9:0] ST_TX = 10'h100; // Byte shift including acknowledge bit.
	localparam [9:0] ST_AK = 10'h200; // Acknowledge sequence.
	// ----------------------------------------------------------------
	// Pin synchronisers.
	// ----------------------------------------------------------------
	reg scl_m_q; // First stage, read only by second.
	reg sda_m_q; // First stage, read only by second.
	reg scl_q; // Synchronised clock line.
	reg sda_q; // Synchronised data line.
	reg scl_p_q; // Previous clock level for edges.
	reg sda_p_q; // Previous data level for edges.
	// ----------------------------------------------------------------
	// Registers and state.
	// ----------------------------------------------------------------
	reg en_q; // Port enable.
	reg ie_q; // Interrupt enable.
	reg [4:0] cmd_q; // Sequence enables and acknowledge data.
	reg [7:0] baud_q; // Baud reload value.
	reg [7:0] buf_q; // Transfer buffer.
	reg bf_q; // Buffer full.
	reg write_collision_flag_q; // Write collision.
	reg bcol_q; // Bus collision.
	reg evt_q; // Serial event.
	reg ackstat_q; // Last acknowledge seen.
	reg sseen_q; // Start seen.
	reg pseen_q; // Stop seen.
	reg [9:0] st_q; // Sequencer state.
	reg [7:0] cnt_q; // Baud counter.
	reg run_q; // Counter running.
	reg half_q; // Clock phase inside a bit: 0 low, 1 high.
	reg [3:0] bit_q; // Bit index within byte, 8 is acknowledge.
	reg [7:0] sh_q; // Shift register.
	reg drv_scl_q; // Pull the clock low.
	reg drv_sda_q; // Pull the data line low.
	// ----------------------------------------------------------------
	// Bus decode and events.
	// ----------------------------------------------------------------
	wire acc = i_psel & i_penable;
	wire wr = acc & i_pwrite;
	wire wr_buf = wr & (i_paddr == `TMB_OFF_BUF);
	wire wr_cmd = wr & (i_paddr == `TMB_OFF_CMD);
	wire wr_stat = wr & (i_paddr == `TMB_OFF_STAT);
	wire idle = (st_q == ST_IDLE);
	wire tick = run_q & (cnt_q == 8'h00);
	// Start and stop seen on the bus, with clock high.
	wire start_det = scl_q & scl_p_q & sda_p_q & ~sda_q;
	wire stop_det = scl_q & scl_p_q & ~sda_p_q & sda_q;
	// A buffer write is refused outside idle.
	wire buf_ok = wr_buf & idle & en_q;
	// ----------------------------------------------------------------
	// Synchronisers: two flops before any logic reads the pins.
	// ----------------------------------------------------------------
	always @(posedge i_clk) begin
		if (!i_reset_n) begin
			scl_m_q <= 1'b1;
			sda_m_q <= 1'b1;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_m_q <= i_scl;
			sda_m_q <= i_sda;
			scl_q <= scl_m_q;
			sda_q <= sda_m_q;
			scl_p_q <= scl_q;
			sda_p_q <= sda_q;
		end
	end
	// ----------------------------------------------------------------
	// APB answer: one wait-free access cycle, unmapped reads zero with error.
	// ----------------------------------------------------------------
	always @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_prdata <= 32'h00000000;
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
		end else begin
			o_pready <= i_psel & ~i_penable;
			o_pslverr <= 1'b0;
			o_prdata <= 32'h00000000;
			if (i_psel & ~i_penable) begin
				case (i_paddr)
					`TMB_OFF_CTRL: o_prdata <= {30'h0, ie_q, en_q};
					`TMB_OFF_CMD: o_prdata <= {27'h0, cmd_q};
					`TMB_OFF_STAT: o_prdata <= {25'h0, ackstat_q, evt_q, bcol_q,
						write_collision_flag_q, bf_q, pseen_q, sseen_q};
					`TMB_OFF_BUF: o_prdata <= {24'h0, buf_q};
					`TMB_OFF_BAUD: o_prdata <= {24'h0, baud_q};
					default: o_pslverr <= 1'b1;
				endcase
			end
		end
	end
	// ----------------------------------------------------------------
	// Software registers that the sequencer does not touch.
	// ----------------------------------------------------------------
	always @(posedge i_clk) begin
		if (!i_reset_n) begin
			en_q <= 1'b0;
			ie_q <= 1'b0;
			baud_q <= `TMB_BAUD_RST;
		end else if (wr) begin
			if (i_paddr == `TMB_OFF_CTRL) begin
				en_q <= i_pwdata[`TMB_CTRL_EN];
				ie_q <= i_pwdata[`TMB_CTRL_IE];
			end
			// The reload value is taken as written; zero to two is a misuse.
			if (i_paddr == `TMB_OFF_BAUD) begin
				baud_q <= i_pwdata[7:0];
			end
		end
	end
	// ----------------------------------------------------------------
	// Bus monitor: start and stop seen, cleared on reset or disable.
	// ----------------------------------------------------------------
	always @(posedge i_clk) begin
		if (!i_reset_n || !en_q) begin
			sseen_q <= 1'b0;
			pseen_q <= 1'b0;
		end else if (start_det) begin
			sseen_q <= 1'b1;
			pseen_q <= 1'b0;
		end else if (stop_det) begin
			// Set stop-seen marks a free bus for software.
			pseen_q <= 1'b1;
			sseen_q <= 1'b0;
		end
	end
	// ----------------------------------------------------------------
	// Interrupt line: event flag or collision, gated by enable.
	// The event path has no clock gating; there is no slave role, so no slave-role wake.
	// ----------------------------------------------------------------
	always @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= ie_q & (evt_q | bcol_q);
		end
	end
	// ----------------------------------------------------------------
	// Pin drivers: only ever pull low, else release.
	// ----------------------------------------------------------------
	always @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_scl <= 1'b0;
			o_sda <= 1'b0;
			o_scl_oe_n <= 1'b1;
			o_sda_oe_n <= 1'b1;
		end else begin
			o_scl <= 1'b0;
			o_sda <= 1'b0;
			o_scl_oe_n <= ~drv_scl_q;
			o_sda_oe_n <= ~drv_sda_q;
		end
	end
	// ----------------------------------------------------------------
	// Sequencer, baud counter and flags.
	// ----------------------------------------------------------------
	always @(posedge i_clk) begin
		if (!i_reset_n || !en_q) begin
			// Reset or disable ends any transfer and frees the lines.
			st_q <= ST_IDLE;
			cnt_q <= 8'h00;
			run_q <= 1'b0;
			half_q <= 1'b0;
			bit_q <= 4'h0;
			sh_q <= 8'h00;
			drv_scl_q <= 1'b0;
			drv_sda_q <= 1'b0;
			cmd_q <= 5'h00;
			buf_q <= 8'h00;
			bf_q <= 1'b0;
			write_collision_flag_q <= 1'b0;
			bcol_q <= 1'b0;
			evt_q <= 1'b0;
			ackstat_q <= 1'b0;
		end else begin
			// Software clears sticky flags; hardware sets below win.
			if (wr_stat) begin
				if (i_pwdata[`TMB_ST_WRITE_COLLISION_FLAG]) write_collision_flag_q <= 1'b0;
				if (i_pwdata[`TMB_ST_BCOL]) bcol_q <= 1'b0;
				if (i_pwdata[`TMB_ST_EVT]) evt_q <= 1'b0;
			end
			if (wr_cmd && idle) begin
				cmd_q <= i_pwdata[4:0];
			end
			if (wr_buf && !buf_ok) begin
				write_collision_flag_q <= 1'b1;
			end
			// A stop on the busy bus always raises the event flag.
			if (stop_det && sseen_q) begin
				evt_q <= 1'b1;
			end
			// Reload counter, counts only while run_q is set; two ticks per bus clock.
			if (run_q) begin
				cnt_q <= (cnt_q == 8'h00) ? baud_q : cnt_q - 8'h01;
			end
			case (st_q)
				ST_IDLE: begin
					run_q <= 1'b0; // Counter stops, clock pin holds.
					if (buf_ok) begin
						// New byte always begins at its first bit.
						buf_q <= i_pwdata[7:0];
						sh_q <= i_pwdata[7:0];
						bf_q <= 1'b1;
						bit_q <= 4'h0;
						half_q <= 1'b0;
						drv_scl_q <= 1'b1;
						drv_sda_q <= ~i_pwdata[7];
						cnt_q <= baud_q;
						run_q <= 1'b1;
						st_q <= ST_TX;
					end else if (cmd_q[`TMB_CMD_START]) begin
						if (!sda_q || !scl_q) begin
							bcol_q <= 1'b1;
							cmd_q[`TMB_CMD_START] <= 1'b0;
						end else begin
							cnt_q <= baud_q;
							run_q <= 1'b1;
							st_q <= ST_S1;
						end
					end else if (cmd_q[`TMB_CMD_RSTART]) begin
						drv_sda_q <= 1'b0;
						cnt_q <= baud_q;
						run_q <= 1'b1;
						st_q <= ST_R1;
					end else if (cmd_q[`TMB_CMD_STOP]) begin
						drv_sda_q <= 1'b1;
						drv_scl_q <= 1'b0;
						st_q <= ST_P1;
					end else if (cmd_q[`TMB_CMD_ACK]) begin
						drv_scl_q <= 1'b1;
						drv_sda_q <= ~cmd_q[`TMB_CMD_ACKDT];
						cnt_q <= baud_q;
						run_q <= 1'b1;
						half_q <= 1'b0;
						st_q <= ST_AK;
					end
				end
				ST_S1: begin
					if (!sda_q) begin
						drv_sda_q <= 1'b1;
						cnt_q <= baud_q;
						st_q <= ST_S2;
					end else if (!scl_q) begin
						bcol_q <= 1'b1;
						cmd_q[`TMB_CMD_START] <= 1'b0;
						run_q <= 1'b0;
						st_q <= ST_IDLE;
					end else if (tick) begin
						drv_sda_q <= 1'b1;
						st_q <= ST_S2;
					end
				end
				ST_S2: begin
					// Clock level is not checked in this count.
					if (tick) begin
						drv_scl_q <= 1'b1;
						cmd_q[`TMB_CMD_START] <= 1'b0;
						evt_q <= 1'b1;
						run_q <= 1'b0;
						st_q <= ST_IDLE;
					end
				end
				ST_R1: begin
					if (tick) begin
						drv_scl_q <= 1'b0;
						run_q <= 1'b0;
						st_q <= ST_R2;
					end
				end
				ST_R2: begin
					if (!run_q) begin
						if (scl_q) begin
							if (!sda_q) begin
								bcol_q <= 1'b1;
								cmd_q[`TMB_CMD_RSTART] <= 1'b0;
								st_q <= ST_IDLE;
							end else begin
								cnt_q <= baud_q;
								run_q <= 1'b1;
							end
						end
					end else if (!scl_q && sda_q) begin
						bcol_q <= 1'b1;
						cmd_q[`TMB_CMD_RSTART] <= 1'b0;
						run_q <= 1'b0;
						st_q <= ST_IDLE;
					end else if (tick) begin
						drv_sda_q <= 1'b1;
						st_q <= ST_R3;
					end
				end
				ST_R3: begin
					if (tick) begin
						drv_scl_q <= 1'b1;
						cmd_q[`TMB_CMD_RSTART] <= 1'b0;
						evt_q <= 1'b1;
						run_q <= 1'b0;
						st_q <= ST_IDLE;
					end
				end
				ST_P1: begin
					if (!run_q) begin
						if (scl_q) begin
							cnt_q <= baud_q;
							run_q <= 1'b1;
						end
					end else if (!scl_q) begin
						bcol_q <= 1'b1;
						drv_sda_q <= 1'b0;
						cmd_q[`TMB_CMD_STOP] <= 1'b0;
						run_q <= 1'b0;
						st_q <= ST_IDLE;
					end else if (tick) begin
						drv_sda_q <= 1'b0;
						st_q <= ST_P2;
					end
				end
				ST_P2: begin
					if (tick) begin
						if (!sda_q) begin
							bcol_q <= 1'b1;
						end else begin
							evt_q <= 1'b1;
						end
						cmd_q[`TMB_CMD_STOP] <= 1'b0;
						run_q <= 1'b0;
						st_q <= ST_IDLE;
					end
				end
				ST_TX, ST_AK: begin
					if (tick) begin
						if (!half_q) begin
							drv_scl_q <= 1'b0;
							half_q <= 1'b1;
						end else if (scl_q) begin
							// Released one read back as zero: lost arbitration.
							if (!drv_sda_q && !sda_q && (st_q == ST_AK || bit_q != 4'h8)) begin
								bcol_q <= 1'b1;
								bf_q <= 1'b0;
								drv_sda_q <= 1'b0;
								cmd_q[`TMB_CMD_ACK] <= 1'b0;
								run_q <= 1'b0;
								st_q <= ST_IDLE;
							end else if (st_q == ST_AK || bit_q == 4'h8) begin
								if (st_q == ST_TX) ackstat_q <= sda_q;
								drv_scl_q <= 1'b1;
								drv_sda_q <= 1'b0;
								bf_q <= 1'b0;
								cmd_q[`TMB_CMD_ACK] <= 1'b0;
								evt_q <= 1'b1;
								run_q <= 1'b0;
								st_q <= ST_IDLE;
							end else begin
								drv_scl_q <= 1'b1;
								half_q <= 1'b0;
								bit_q <= bit_q + 4'h1;
								sh_q <= {sh_q[6:0], 1'b0};
								drv_sda_q <= (bit_q == 4'h7) ? 1'b0 : ~sh_q[6];
							end
						end else begin
							// Clock held low by another party: stretch.
							cnt_q <= 8'h00;
						end
					end
				end
				default: begin
					st_q <= ST_IDLE;
				end
			endcase
		end
	end
endmodule

// ==== rtl/tmb_regs.vh ====
// Register offsets, field positions and reset values of the two-wire master.
`ifndef TMB_REGS_VH
`define TMB_REGS_VH
// ----------------------------------------------------------------
// Register byte offsets.
// ----------------------------------------------------------------
`define TMB_OFF_CTRL 12'h000
`define TMB_OFF_CMD 12'h004
`define TMB_OFF_STAT 12'h008
`define TMB_OFF_BUF 12'h00C
`define TMB_OFF_BAUD 12'h010
// ----------------------------------------------------------------
// Control register fields.
// ----------------------------------------------------------------
`define TMB_CTRL_EN 0
`define TMB_CTRL_IE 1
// ----------------------------------------------------------------
// Command register fields (sequence enables and acknowledge data).
// ----------------------------------------------------------------
`define TMB_CMD_START 0
`define TMB_CMD_RSTART 1
`define TMB_CMD_STOP 2
`define TMB_CMD_ACK 3
`define TMB_CMD_ACKDT 4
// ----------------------------------------------------------------
// Status register fields; write one to clear the sticky ones.
// ----------------------------------------------------------------
`define TMB_ST_START 0
`define TMB_ST_STOP 1
`define TMB_ST_BF 2
`define TMB_ST_WRITE_COLLISION_FLAG 3
`define TMB_ST_BCOL 4
`define TMB_ST_EVT 5
`define TMB_ST_ACKSTAT 6
// ----------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------
`define TMB_BAUD_RST 8'h09
`endif

// ==== tb/tmb_master_sva.sv ====
// Port checker for the two-wire master, bound to its top module.
`timescale 1ns/100ps
`include "tmb_regs.vh"
module tmb_master_chk (
	input wire i_clk,
	input wire i_reset_n,
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [11:0] i_paddr,
	input wire [31:0] i_pwdata,
	input wire o_pready,
	input wire o_pslverr,
	input wire i_scl,
	input wire o_scl,
	input wire o_scl_oe_n,
	input wire o_sda,
	input wire o_sda_oe_n,
	input wire o_irq
);
	// ----------------------------------------------------------------
	// Shadow state.
	// ----------------------------------------------------------------
	reg [7:0] baud_q; // Copy of the reload value.
	reg ie_q; // Copy of the interrupt enable.
	reg sda_oe_q; // Data enable one cycle ago.
	reg arm_q; // A start edge was driven with the clock released.
	reg [8:0] st_cnt_q; // Cycles since that start edge.
	reg [8:0] low_cnt_q; // Cycles the clock has been held low, saturating.
	wire wr_acc = i_psel && i_penable && i_pwrite && o_pready;
	wire [8:0] half = {1'b0, baud_q} + 9'h001;
	default clocking cb @(posedge i_clk);
	endclocking
	// Snoops writes and counts phases so timing can be judged.
	always @(posedge i_clk) begin
		if (!i_reset_n) begin
			baud_q <= `TMB_BAUD_RST;
			ie_q <= 1'b0;
			sda_oe_q <= 1'b1;
			arm_q <= 1'b0;
			st_cnt_q <= 9'h000;
			low_cnt_q <= 9'h000;
		end else begin
			sda_oe_q <= o_sda_oe_n;
			if (wr_acc && i_paddr == `TMB_OFF_BAUD) begin
				baud_q <= i_pwdata[7:0];
			end
			if (wr_acc && i_paddr == `TMB_OFF_CTRL) begin
				ie_q <= i_pwdata[`TMB_CTRL_IE];
			end
			if (sda_oe_q && !o_sda_oe_n && o_scl_oe_n) begin
				arm_q <= 1'b1;
				st_cnt_q <= 9'h001;
			end else if (!o_scl_oe_n || o_sda_oe_n) begin
				arm_q <= 1'b0;
			end else begin
				st_cnt_q <= st_cnt_q + 9'h001;
			end
			if (o_scl_oe_n) begin
				low_cnt_q <= 9'h000;
			end else begin
				low_cnt_q <= low_cnt_q + {8'h00, ~&low_cnt_q};
			end
		end
	end
	// ----------------------------------------------------------------
	// Assertions.
	// ----------------------------------------------------------------
	chk_reset_quiet: assert property (!i_reset_n |=> o_scl_oe_n && o_sda_oe_n && !o_irq)
		else $error("lines or irq active after reset");
	chk_lines_low_only: assert property (disable iff (!i_reset_n) !o_scl && !o_sda)
		else $error("bus line driven high");
	chk_start_hold: assert property (disable iff (!i_reset_n)
		arm_q && !o_scl_oe_n |-> st_cnt_q == half) else $error("start hold time wrong");
	chk_scl_low_min: assert property (disable iff (!i_reset_n)
		o_scl_oe_n && low_cnt_q != 9'h000 |-> low_cnt_q >= half) else $error("clock low too short");
	chk_start_line_low: assert property (disable iff (!i_reset_n)
		wr_acc && i_paddr == `TMB_OFF_CMD && i_pwdata[`TMB_CMD_START] && o_scl_oe_n && o_sda_oe_n
		&& !i_scl && $past(i_scl, 3) == 1'b0 |=> (o_scl_oe_n && o_sda_oe_n) [*8])
		else $error("start driven on a busy line");
	chk_irq_needs_ie: assert property (disable iff (!i_reset_n)
		o_irq |-> ie_q || $past(ie_q)) else $error("irq without enable");
	chk_ready_first: assert property (disable iff (!i_reset_n)
		i_psel && $rose(i_penable) |-> o_pready) else $error("ready late");
	chk_ready_pulse: assert property (disable iff (!i_reset_n)
		o_pready |=> !o_pready) else $error("ready longer than one cycle");
	cov_start_seq: cover property (arm_q && !o_scl_oe_n);
	cov_irq: cover property ($rose(o_irq));
	cov_slverr: cover property (o_pslverr);
endmodule
bind tmb_master tmb_master_chk chk_u (.i_clk, .i_reset_n, .i_psel, .i_penable, .i_pwrite,
	.i_paddr, .i_pwdata, .o_pready, .o_pslverr, .i_scl, .o_scl, .o_scl_oe_n, .o_sda,
	.o_sda_oe_n, .o_irq);

// ==== tb/tmb_bus_peer.sv ====
// Model of the other parties on the shared two-wire bus: pull-ups, a slave and a rival.
`timescale 1ns/100ps
module tmb_bus_peer (
	input wire i_clk,
	input wire i_scl_oe_n,
	input wire i_scl_dv,
	input wire i_sda_oe_n,
	input wire i_sda_dv,
	input wire i_pull_scl,
	input wire i_pull_sda,
	output wire o_scl,
	output wire o_sda,
	output reg [3:0] o_cnt = 4'h0,
	output reg [7:0] o_byte = 8'h00
);
	reg scl_d = 1'b1; // Clock level one cycle ago.
	reg sda_d = 1'b1; // Data level one cycle ago.
	reg ack_q = 1'b0; // Slave holds data low for the acknowledge bit.
	// Wired-AND with pull-ups: any party pulling low wins.
	assign o_scl = (i_scl_oe_n | i_scl_dv) & !i_pull_scl;
	assign o_sda = (i_sda_oe_n | i_sda_dv) & !i_pull_sda & !ack_q;
	// Slave shifts bits MSB first on rising clock and acknowledges after eight.
	always @(posedge i_clk) begin
		scl_d <= o_scl;
		sda_d <= o_sda;
		if (o_scl && scl_d && sda_d && !o_sda) begin
			o_cnt <= 4'h0;
			ack_q <= 1'b0;
		end else if (o_scl && !scl_d) begin
			o_cnt <= o_cnt + 4'h1;
			if (o_cnt < 4'h8) begin
				o_byte <= {o_byte[6:0], o_sda};
			end
		end else if (!o_scl && scl_d) begin
			ack_q <= (o_cnt == 4'h8);
			if (o_cnt == 4'h9) begin
				o_cnt <= 4'h0;
			end
		end
	end
endmodule

// ==== tb/tmb_master_tb_top.sv ====
// Self-checking bench of the two-wire master driven over APB.
`timescale 1ns/100ps
`include "tmb_regs.vh"
module tmb_master_tb_top;
	reg clk, rst_n, psel, pen, pwr, pull_scl, pull_sda;
	reg [11:0] paddr;
	reg [31:0] pwdata, rd;
	reg err;
	wire [31:0] prdata;
	wire pready, pslverr, scl, sda, scl_oe_n, sda_oe_n, scl_dv, sda_dv, irq;
	wire [3:0] p_cnt;
	wire [7:0] p_byte;
	integer n_fail, comparisons, k;
	tmb_master dut_u (.i_clk(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_scl(scl), .o_scl(scl_dv),
		.o_scl_oe_n(scl_oe_n), .i_sda(sda), .o_sda(sda_dv), .o_sda_oe_n(sda_oe_n), .o_irq(irq));
	tmb_bus_peer peer_u (.i_clk(clk), .i_scl_oe_n(scl_oe_n), .i_scl_dv(scl_dv),
		.i_sda_oe_n(sda_oe_n), .i_sda_dv(sda_dv), .i_pull_scl(pull_scl), .i_pull_sda(pull_sda),
		.o_scl(scl), .o_sda(sda), .o_cnt(p_cnt), .o_byte(p_byte));
	// 200 MHz clock.
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Prints the verdict and ends the run.
	task print_verdict;
		begin
			if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
			else $display("Finished with errors");
			$finish;
		end
	endtask
	// Compares one value and reports a mismatch.
	task chk(input [31:0] got, input [31:0] exp);
		begin
			comparisons = comparisons + 1;
			if (got !== exp) begin
				n_fail = n_fail + 1;
				$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	// One APB transfer; read data lands in rd and the error flag in err.
	task apb(input [11:0] a, input w, input [31:0] d);
		integer t;
		begin
			@(posedge clk);
			psel <= 1'b1;
			pen <= 1'b0;
			pwr <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge clk);
			pen <= 1'b1;
			t = 0;
			do begin
				@(posedge clk);
				t = t + 1;
			end while (pready !== 1'b1 && t < 20);
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			pen <= 1'b0;
			if (t >= 20) begin
				n_fail = n_fail + 1;
				print_verdict;
			end
		end
	endtask
	// Polls the status register until bit b is set.
	task wait_st(input integer b);
		integer t;
		begin
			t = 0;
			do begin
				apb(`TMB_OFF_STAT, 1'b0, 32'h0);
				t = t + 1;
			end while (rd[b] !== 1'b1 && t < 400);
			if (t >= 400) begin
				n_fail = n_fail + 1;
				print_verdict;
			end
		end
	endtask
	// Sends a start, clears the event, then loads a byte.
	task go(input [7:0] b);
		begin
			apb(`TMB_OFF_CMD, 1'b1, 32'h1);
			wait_st(`TMB_ST_EVT);
			apb(`TMB_OFF_STAT, 1'b1, 32'h20);
			apb(`TMB_OFF_BUF, 1'b1, {24'h0, b});
		end
	endtask
	// ----------------------------------------------------------------
	// Main sequence.
	// ----------------------------------------------------------------
	initial begin
		rst_n = 1'b0; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = 12'h0; pwdata = 32'h0;
		pull_scl = 1'b0; pull_sda = 1'b0; n_fail = 0; comparisons = 0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		apb(`TMB_OFF_BAUD, 1'b0, 32'h0);
		chk(rd, 32'h9);
		apb(`TMB_OFF_STAT, 1'b0, 32'h0);
		chk(rd, 32'h0);
		apb(12'h014, 1'b0, 32'h0);
		chk({rd[30:0], err}, 32'h1);
		apb(`TMB_OFF_BAUD, 1'b1, 32'h3);
		apb(`TMB_OFF_CTRL, 1'b1, 32'h3);
		go(8'hA5);
		wait_st(`TMB_ST_EVT);
		chk(32'(p_byte), 32'hA5);
		chk(32'(rd[`TMB_ST_ACKSTAT]), 32'h0);
		// A rival pulls data low while this master sends ones.
		apb(`TMB_OFF_STAT, 1'b1, 32'h20);
		apb(`TMB_OFF_BUF, 1'b1, 32'hFF);
		for (k = 0; k < 300 && p_cnt != 4'h2; k = k + 1) @(posedge clk);
		if (k >= 300) begin
			n_fail = n_fail + 1;
			print_verdict;
		end
		pull_sda <= 1'b1;
		wait_st(`TMB_ST_BCOL);
		chk(32'(rd[`TMB_ST_BF]), 32'h0);
		chk(32'({scl_oe_n, sda_oe_n}), 32'h3);
		chk(32'(irq), 32'h1);
		apb(`TMB_OFF_CMD, 1'b0, 32'h0);
		chk(rd, 32'h0);
		apb(`TMB_OFF_STAT, 1'b1, 32'h38);
		pull_sda <= 1'b0;
		wait_st(`TMB_ST_EVT);
		chk(32'(rd[`TMB_ST_STOP]), 32'h1);
		chk(32'(irq), 32'h1);
		// Bus is free now that a stop was seen.
		apb(`TMB_OFF_STAT, 1'b1, 32'h38);
		go(8'h5A);
		wait_st(`TMB_ST_EVT);
		chk(32'(p_byte), 32'h5A);
		// Repeated start, then a not-acknowledge sequence on the held bus.
		apb(`TMB_OFF_STAT, 1'b1, 32'h20);
		apb(`TMB_OFF_CMD, 1'b1, 32'h2);
		wait_st(`TMB_ST_EVT);
		chk(32'(rd[`TMB_ST_START]), 32'h1);
		chk(32'({scl_oe_n, sda_oe_n, p_cnt}), 32'h0);
		apb(`TMB_OFF_STAT, 1'b1, 32'h20);
		apb(`TMB_OFF_CMD, 1'b1, 32'h18);
		wait_st(`TMB_ST_EVT);
		chk(32'({rd[`TMB_ST_BCOL], p_cnt}), 32'h1);
		apb(`TMB_OFF_STAT, 1'b1, 32'h20);
		apb(`TMB_OFF_CMD, 1'b1, 32'h4);
		apb(`TMB_OFF_BUF, 1'b1, 32'h33);
		apb(`TMB_OFF_STAT, 1'b0, 32'h0);
		chk(32'(rd[`TMB_ST_WRITE_COLLISION_FLAG]), 32'h1);
		apb(`TMB_OFF_BUF, 1'b0, 32'h0);
		chk(rd, 32'h5A);
		wait_st(`TMB_ST_EVT);
		chk(32'({scl_oe_n, sda_oe_n}), 32'h3);
		// A rival holds the clock low when a start is asked for.
		apb(`TMB_OFF_STAT, 1'b1, 32'h38);
		pull_scl <= 1'b1;
		repeat (4) @(posedge clk);
		apb(`TMB_OFF_CMD, 1'b1, 32'h1);
		wait_st(`TMB_ST_BCOL);
		apb(`TMB_OFF_CMD, 1'b0, 32'h0);
		chk(rd, 32'h0);
		pull_scl <= 1'b0;
		apb(`TMB_OFF_CTRL, 1'b1, 32'h0);
		apb(`TMB_OFF_STAT, 1'b0, 32'h0);
		chk(32'(rd[1:0]), 32'h0);
		// Reset in the middle of a byte.
		apb(`TMB_OFF_CTRL, 1'b1, 32'h3);
		go(8'hFF);
		repeat (20) @(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk(32'({scl_oe_n, sda_oe_n}), 32'h3);
		apb(`TMB_OFF_CTRL, 1'b0, 32'h0);
		chk(rd, 32'h0);
		print_verdict;
	end
endmodule
